// *** slbst_pkg.sv ***
// Purpose: shared constants and types of the serial link self-test block
// Assumes: one clock, CLK at 100 MHz; back-channel frames arrive already deserialized on CLK
// Notes: register offsets are byte addresses on a 32-bit Avalon-MM slave
//
// How it works
// - The far end sends a test-enable indication over the back channel and the block enters self-test mode on it.
// - In self-test mode video input is ignored and an all-zero payload goes through scrambling and DC balancing.
// - The test clock is the input clock or the internal oscillator, chosen at the far end, and the block follows it.
// - Lock stays valid through the test because the block keeps driving the link at speed.
// - When the far end ends the test the block leaves self-test mode and sends sampled video again.
// - Every back-channel frame received while locked has its CRC field checked and errors are tracked.
// - CRC checking runs only while the back channel is locked, shown in link status bit 0 at 0x0C.
// - Back-channel CRC errors count in an 8-bit register that is cleared on entry to self-test mode.
// - From the moment of entry the functional-mode CRC error register records back-channel CRC errors.
// - The test-mode CRC error register counts only in self-test mode and keeps its value until cleared or re-entry.
package slbst_pkg;
   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int PAY_W = 24;
   localparam int BC_W = 16;
   localparam int CRC_W = 8;
   localparam int CNT_W = 8;
   localparam int RD_W = 8;
   localparam int ADDR_W = 6;
   localparam int IRQ_W = 3;

   // ---------------------------------------------------------------
   // back-channel frame fields and crc
   // ---------------------------------------------------------------
   localparam int BC_TEST_BIT = 0;
   localparam int BC_OSC_BIT = 1;
   localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;
   localparam logic [CRC_W-1:0] CRC_INIT = 8'h00;

   // ---------------------------------------------------------------
   // scrambler
   // ---------------------------------------------------------------
   localparam logic [PAY_W-1:0] SCR_TAPS = 24'hE10000;
   localparam logic [PAY_W-1:0] SCR_SEED = 24'hFFFFFF;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 6'h04;
   localparam logic [ADDR_W-1:0] ADDR_LINK = 6'h0C;
   localparam logic [ADDR_W-1:0] ADDR_FCNT = 6'h10;
   localparam logic [ADDR_W-1:0] ADDR_TCNT = 6'h14;
   localparam logic [ADDR_W-1:0] ADDR_ISTAT = 6'h18;
   localparam logic [ADDR_W-1:0] ADDR_ICLR = 6'h1C;
   localparam logic [ADDR_W-1:0] ADDR_IEN = 6'h20;
   localparam int CTRL_TCLR = 0;
   localparam int CTRL_FCLR = 1;
   localparam int CTRL_HOLD = 5;
   localparam int LINK_DET = 0;
   localparam int LINK_TEST = 1;
   localparam int LINK_OSC = 2;
   localparam int IRQ_ENTER = 0;
   localparam int IRQ_EXIT = 1;
   localparam int IRQ_CRC = 2;

   typedef enum {ST_NORMAL, ST_TEST} slbst_mode_t;
endpackage

// *** slbst_frm_if.sv ***
// Purpose: checked back-channel frame results from the crc checker to the top
// Assumes: all signals on CLK
// Notes: ok and err are one-cycle pulses, one of them per frame while locked
interface slbst_frm_if;
   logic ok;
   logic err;
   logic test_req;
   logic osc_sel;
   modport chk (output ok, output err, output test_req, output osc_sel);
   modport use_side (input ok, input err, input test_req, input osc_sel);
endinterface

// *** slbst_sat_cnt.sv ***
// Purpose: saturating error counter with synchronous clear
// Assumes: inc and clr are single-cycle qualified strobes
// Notes: an increment in the clear cycle is kept, so the count restarts at one
module slbst_sat_cnt #(
   parameter int W = slbst_pkg::CNT_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clr,
   input wire logic inc,
   output logic [W-1:0] cnt
);
   localparam logic [W-1:0] CNT_MAX = '1;
   localparam logic [W-1:0] CNT_ONE = W'(1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
      end else if (clr) begin
         cnt <= inc ? CNT_ONE : '0;
      end else if (inc && cnt != CNT_MAX) begin
         cnt <= cnt + CNT_ONE;
      end
   end

   property p_sat;
      @(posedge clk) disable iff (!rst_n) (cnt == CNT_MAX && !clr) |=> cnt == CNT_MAX;
   endproperty
   a_sat: assert property (p_sat) else $error("counter left its maximum");

   property p_step;
      @(posedge clk) disable iff (!rst_n) (inc && !clr && cnt != CNT_MAX) |=> cnt == $past(cnt) + CNT_ONE;
   endproperty
   a_step: assert property (p_step) else $error("counter missed an increment");
endmodule // slbst_sat_cnt

// *** slbst_crc_chk.sv ***
// Purpose: crc check of received back-channel frames
// Assumes: frm_valid is a one-cycle strobe with frm_data and frm_crc on CLK
// Notes: frames seen while unlocked are dropped whole, test request bits included
module slbst_crc_chk #(
   parameter int BC_W = slbst_pkg::BC_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic lock,
   input wire logic frm_valid,
   input wire logic [BC_W-1:0] frm_data,
   input wire logic [slbst_pkg::CRC_W-1:0] frm_crc,
   slbst_frm_if.chk fo
);
   function automatic logic [slbst_pkg::CRC_W-1:0] crc_calc(input logic [BC_W-1:0] d);
      logic [slbst_pkg::CRC_W-1:0] c;
      c = slbst_pkg::CRC_INIT;
      for (int i = BC_W - 1; i >= 0; i--) begin
         if (c[slbst_pkg::CRC_W-1] ^ d[i]) begin
            c = {c[slbst_pkg::CRC_W-2:0], 1'b0} ^ slbst_pkg::CRC_POLY;
         end else begin
            c = {c[slbst_pkg::CRC_W-2:0], 1'b0};
         end
      end
      return c;
   endfunction

   logic take;
   logic good;
   logic ok_ff;
   logic err_ff;
   logic test_req_ff;
   logic osc_sel_ff;

   assign take = frm_valid && lock;
   assign good = crc_calc(frm_data) == frm_crc;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ok_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         ok_ff <= take && good;
         err_ff <= take && !good;
      end
   end

   // request bits only trusted from frames that passed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         test_req_ff <= 1'b0;
         osc_sel_ff <= 1'b0;
      end else if (take && good) begin
         test_req_ff <= frm_data[slbst_pkg::BC_TEST_BIT];
         osc_sel_ff <= frm_data[slbst_pkg::BC_OSC_BIT];
      end
   end

   assign fo.ok = ok_ff;
   assign fo.err = err_ff;
   assign fo.test_req = test_req_ff;
   assign fo.osc_sel = osc_sel_ff;

   property p_nolock;
      @(posedge clk) disable iff (!rst_n) !lock |=> !(ok_ff || err_ff);
   endproperty
   a_nolock: assert property (p_nolock) else $error("frame checked while unlocked");

   property p_bad;
      @(posedge clk) disable iff (!rst_n) (take && crc_calc(frm_data) != frm_crc) |=> err_ff && !ok_ff;
   endproperty
   a_bad: assert property (p_bad) else $error("crc error not flagged");
endmodule // slbst_crc_chk

// *** slbst_top.sv ***
// Purpose: serializer-side self test of the serial link and its back channel
// Assumes: video input and back-channel frame strobes are synchronous to CLK
// Notes: the test clock source is exported as a mux select; the clock mux itself sits outside
//
// Our own choices: the address map and register access over Avalon-MM.
module slbst_top #(
   parameter int PAY_W = slbst_pkg::PAY_W,
   parameter int BC_W = slbst_pkg::BC_W,
   parameter int CNT_W = slbst_pkg::CNT_W
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [slbst_pkg::ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic BC_LOCK,
   input wire logic BC_FRAME_VALID,
   input wire logic [BC_W-1:0] BC_FRAME_DATA,
   input wire logic [slbst_pkg::CRC_W-1:0] BC_FRAME_CRC,
   input wire logic [PAY_W-1:0] VID_DATA,
   input wire logic VID_VALID,
   output logic [PAY_W:0] TX_DATA,
   output logic TX_VALID,
   output logic TX_CLK_SEL_OSC,
   output logic SELF_TEST_ACTIVE,
   output logic IRQ
);
   localparam logic [slbst_pkg::RD_W-1:0] PAY_W_RD = slbst_pkg::RD_W'(PAY_W);

   // ---------------------------------------------------------------
   // back-channel check and counters
   // ---------------------------------------------------------------
   slbst_frm_if frm ();

   slbst_crc_chk #(.BC_W(BC_W)) u_chk (
      .clk(CLK),
      .rst_n(RST_N),
      .lock(BC_LOCK),
      .frm_valid(BC_FRAME_VALID),
      .frm_data(BC_FRAME_DATA),
      .frm_crc(BC_FRAME_CRC),
      .fo(frm)
   );

   slbst_pkg::slbst_mode_t mode_ff;
   slbst_pkg::slbst_mode_t nxt_mode;
   logic in_test;
   logic entry;
   logic leave;
   logic wr_ok;
   logic wr_ctrl;
   logic fcnt_clr;
   logic tcnt_clr;
   logic tcnt_inc;
   logic [CNT_W-1:0] fcnt;
   logic [CNT_W-1:0] tcnt;

   assign in_test = mode_ff == slbst_pkg::ST_TEST;
   assign entry = frm.ok && frm.test_req && !in_test;
   assign leave = frm.ok && !frm.test_req && in_test;
   assign wr_ctrl = wr_ok && AVS_ADDRESS == slbst_pkg::ADDR_CTRL;
   assign fcnt_clr = entry || (wr_ctrl && AVS_WRITEDATA[slbst_pkg::CTRL_FCLR]);
   assign tcnt_clr = entry || (wr_ctrl && AVS_WRITEDATA[slbst_pkg::CTRL_TCLR]);
   assign tcnt_inc = frm.err && in_test;

   // functional counter runs from the entry cycle on
   slbst_sat_cnt #(.W(CNT_W)) u_fcnt (
      .clk(CLK),
      .rst_n(RST_N),
      .clr(fcnt_clr),
      .inc(frm.err),
      .cnt(fcnt)
   );

   slbst_sat_cnt #(.W(CNT_W)) u_tcnt (
      .clk(CLK),
      .rst_n(RST_N),
      .clr(tcnt_clr),
      .inc(tcnt_inc),
      .cnt(tcnt)
   );

   // ---------------------------------------------------------------
   // mode control
   // ---------------------------------------------------------------
   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         slbst_pkg::ST_NORMAL: begin
            if (entry) begin
               nxt_mode = slbst_pkg::ST_TEST;
            end
         end
         slbst_pkg::ST_TEST: begin
            if (leave) begin
               nxt_mode = slbst_pkg::ST_NORMAL;
            end
         end
         default: begin
            nxt_mode = slbst_pkg::ST_NORMAL;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_ff <= slbst_pkg::ST_NORMAL;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // clock choice is latched at entry so a stray frame cannot flip it mid-test
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         TX_CLK_SEL_OSC <= 1'b0;
      end else if (entry) begin
         TX_CLK_SEL_OSC <= frm.osc_sel;
      end else if (leave) begin
         TX_CLK_SEL_OSC <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         SELF_TEST_ACTIVE <= 1'b0;
      end else begin
         SELF_TEST_ACTIVE <= nxt_mode == slbst_pkg::ST_TEST;
      end
   end

   // ---------------------------------------------------------------
   // forward payload: source select, scrambler, dc balance
   // ---------------------------------------------------------------
   logic ctrl_hold_ff;
   logic [PAY_W-1:0] lfsr_ff;
   logic signed [slbst_pkg::RD_W-1:0] rd_ff;
   logic [PAY_W-1:0] payload;
   logic [PAY_W-1:0] scr;
   logic send;
   logic [slbst_pkg::RD_W-1:0] pop;
   logic signed [slbst_pkg::RD_W-1:0] disp;
   logic flip;

   assign payload = in_test ? '0 : VID_DATA;
   assign send = in_test || VID_VALID;
   assign scr = payload ^ lfsr_ff;

   always_comb begin
      pop = '0;
      for (int i = 0; i < PAY_W; i++) begin
         pop = pop + slbst_pkg::RD_W'(scr[i]);
      end
   end

   assign disp = $signed({pop[slbst_pkg::RD_W-2:0], 1'b0}) - $signed(PAY_W_RD);
   assign flip = (rd_ff > 0 && disp > 0) || (rd_ff < 0 && disp < 0);

   // hold bit parks the scrambler at its seed so both ends restart aligned
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         lfsr_ff <= slbst_pkg::SCR_SEED;
      end else if (ctrl_hold_ff) begin
         lfsr_ff <= slbst_pkg::SCR_SEED;
      end else if (send) begin
         lfsr_ff <= lfsr_ff[0] ? ((lfsr_ff >> 1) ^ slbst_pkg::SCR_TAPS) : (lfsr_ff >> 1);
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rd_ff <= '0;
         TX_DATA <= '0;
         TX_VALID <= 1'b0;
      end else begin
         TX_VALID <= send;
         if (send) begin
            TX_DATA <= flip ? {1'b1, ~scr} : {1'b0, scr};
            rd_ff <= flip ? rd_ff - disp : rd_ff + disp;
         end
      end
   end

   // ---------------------------------------------------------------
   // interrupts
   // ---------------------------------------------------------------
   logic [slbst_pkg::IRQ_W-1:0] istat_ff;
   logic [slbst_pkg::IRQ_W-1:0] ien_ff;
   logic [slbst_pkg::IRQ_W-1:0] ev;
   logic [slbst_pkg::IRQ_W-1:0] iclr;

   always_comb begin
      ev = '0;
      ev[slbst_pkg::IRQ_ENTER] = entry;
      ev[slbst_pkg::IRQ_EXIT] = leave;
      ev[slbst_pkg::IRQ_CRC] = frm.err;
   end

   assign iclr = (wr_ok && AVS_ADDRESS == slbst_pkg::ADDR_ICLR) ? AVS_WRITEDATA[slbst_pkg::IRQ_W-1:0] : '0;

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         istat_ff <= '0;
      end else begin
         istat_ff <= (istat_ff & ~iclr) | ev;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(istat_ff & ien_ff);
      end
   end

   // ---------------------------------------------------------------
   // avalon-mm slave, one wait cycle per access
   // ---------------------------------------------------------------
   logic req;
   logic [31:0] rdata;

   assign req = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         AVS_WAITREQUEST <= 1'b1;
      end else begin
         AVS_WAITREQUEST <= !req;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_hold_ff <= 1'b0;
      end else if (wr_ctrl) begin
         ctrl_hold_ff <= AVS_WRITEDATA[slbst_pkg::CTRL_HOLD];
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ien_ff <= '0;
      end else if (wr_ok && AVS_ADDRESS == slbst_pkg::ADDR_IEN) begin
         ien_ff <= AVS_WRITEDATA[slbst_pkg::IRQ_W-1:0];
      end
   end

   always_comb begin
      rdata = '0;
      case (AVS_ADDRESS)
         slbst_pkg::ADDR_CTRL: rdata[slbst_pkg::CTRL_HOLD] = ctrl_hold_ff;
         slbst_pkg::ADDR_LINK: begin
            rdata[slbst_pkg::LINK_DET] = BC_LOCK;
            rdata[slbst_pkg::LINK_TEST] = in_test;
            rdata[slbst_pkg::LINK_OSC] = TX_CLK_SEL_OSC;
         end
         slbst_pkg::ADDR_FCNT: rdata[CNT_W-1:0] = fcnt;
         slbst_pkg::ADDR_TCNT: rdata[CNT_W-1:0] = tcnt;
         slbst_pkg::ADDR_ISTAT: rdata[slbst_pkg::IRQ_W-1:0] = istat_ff;
         slbst_pkg::ADDR_IEN: rdata[slbst_pkg::IRQ_W-1:0] = ien_ff;
         default: rdata = '0;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         AVS_READDATA <= '0;
      end else if (req && AVS_READ) begin
         AVS_READDATA <= rdata;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_entry;
      @(posedge CLK) disable iff (!RST_N) entry |=> in_test && SELF_TEST_ACTIVE;
   endproperty
   a_entry: assert property (p_entry) else $error("test request not entered");

   property p_zero;
      @(posedge CLK) disable iff (!RST_N) (in_test && !ctrl_hold_ff)
         |=> (TX_DATA[PAY_W-1:0] == $past(lfsr_ff) || TX_DATA[PAY_W-1:0] == ~$past(lfsr_ff));
   endproperty
   a_zero: assert property (p_zero) else $error("test payload not zero before scrambling");

   property p_clk;
      @(posedge CLK) disable iff (!RST_N) (in_test && !entry && $past(in_test)) |-> $stable(TX_CLK_SEL_OSC);
   endproperty
   a_clk: assert property (p_clk) else $error("clock choice changed during test");

   property p_speed;
      @(posedge CLK) disable iff (!RST_N) in_test |=> TX_VALID;
   endproperty
   a_speed: assert property (p_speed) else $error("link idle during test");

   property p_leave;
      @(posedge CLK) disable iff (!RST_N) leave |=> !in_test && !SELF_TEST_ACTIVE && !TX_CLK_SEL_OSC;
   endproperty
   a_leave: assert property (p_leave) else $error("test not left");

   property p_fclr;
      @(posedge CLK) disable iff (!RST_N) entry |=> fcnt == CNT_W'($past(frm.err));
   endproperty
   a_fclr: assert property (p_fclr) else $error("entry did not restart functional count");

   property p_thold;
      @(posedge CLK) disable iff (!RST_N) (!in_test && !tcnt_clr) |=> $stable(tcnt);
   endproperty
   a_thold: assert property (p_thold) else $error("test count moved outside test");

   property p_tclr;
      @(posedge CLK) disable iff (!RST_N) entry |=> tcnt == '0;
   endproperty
   a_tclr: assert property (p_tclr) else $error("test count not cleared at entry");
endmodule // slbst_top

// *** slbst_far_end.sv ***
// Purpose: far-end model that sends back-channel frames to the serializer
// Assumes: frames are one-cycle strobes on the serializer clock
// Notes: idle frame lines carry the inverse of the last frame, never a held copy
module slbst_far_end (
   input wire logic clk,
   output logic lock,
   output logic frm_valid,
   output logic [15:0] frm_data,
   output logic [7:0] frm_crc,
   input wire logic [24:0] tx_data,
   input wire logic tx_valid,
   output logic result
);
   timeunit 1ns;
   timeprecision 1ns;

   logic testing = 1'h0;
   logic was = 1'h0;
   logic started = 1'h0;
   logic [23:0] prv;
   logic [23:0] w;
   int errs = 0;

   initial begin
      lock = 1'h0;
      frm_valid = 1'h0;
      frm_data = 16'h0000;
      frm_crc = 8'h00;
      result = 1'h0;
   end

   function automatic logic [23:0] step(input logic [23:0] p);
      return p[0] ? ((p >> 1) ^ slbst_pkg::SCR_TAPS) : (p >> 1);
   endfunction

   // zero payload means each word is the next scrambler state; seed words mark a restart
   always @(posedge clk) begin
      w = tx_data[24] ? ~tx_data[23:0] : tx_data[23:0];
      if (testing && !was) begin
         errs = 0;
         started = 1'h0;
      end
      if (!testing && was) begin
         result <= (errs == 0);
      end
      was = testing;
      if (testing && tx_valid) begin
         if (!started) begin
            result <= 1'h1;
         end else if (w != step(prv) && w != slbst_pkg::SCR_SEED) begin
            errs++;
            result <= 1'h0;
         end
         started = 1'h1;
         prv = w;
      end
   end

   // low for half a period per bad word while checking
   always @(negedge clk) begin
      if (testing && started) begin
         result <= 1'h1;
      end
   end

   function automatic logic [7:0] crc8(input logic [15:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 15; i >= 0; i--) begin
         c = (c[7] ^ d[i]) ? ({c[6:0], 1'h0} ^ 8'h07) : {c[6:0], 1'h0};
      end
      return c;
   endfunction

   task automatic set_lock(input logic v);
      @(posedge clk);
      lock <= v;
   endtask

   // test bit stays set for as long as the run should last
   task automatic send(input logic t, input logic o, input logic [13:0] rnd, input logic bad);
      logic [15:0] d;
      d = {rnd, o, t};
      @(posedge clk);
      frm_valid <= 1'h1;
      frm_data <= d;
      frm_crc <= crc8(d) ^ {7'h00, bad};
      if (lock) begin
         testing <= t;
      end
      @(posedge clk);
      frm_valid <= 1'h0;
      frm_data <= ~d;
      frm_crc <= ~frm_crc;
   endtask
endmodule // slbst_far_end

// *** test_serial_link_link_self_test.sv ***
// Purpose: self-checking bench of the serial link self-test block
// Assumes: default parameters; one wait cycle per register access
// Notes: counters and status are predicted by an integer model of the frames sent
module test_serial_link_link_self_test;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk;
   logic rst_n;
   logic [5:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic bc_lock;
   logic bc_valid;
   logic [15:0] bc_data;
   logic [7:0] bc_crc;
   logic [23:0] vid_data;
   logic vid_valid;
   logic [24:0] tx_data;
   logic tx_valid;
   logic tx_osc;
   logic st_active;
   logic irq;
   logic result;
   logic [23:0] vid_prev;
   logic [31:0] seed = 32'h22469A67;
   int fail_count = 0;
   int tests_run = 0;
   int fcnt = 0;
   int tcnt = 0;
   int in_t = 0;
   int ist = 0;

   slbst_top dut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
      .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
      .AVS_WAITREQUEST(avs_waitrequest), .BC_LOCK(bc_lock), .BC_FRAME_VALID(bc_valid),
      .BC_FRAME_DATA(bc_data), .BC_FRAME_CRC(bc_crc), .VID_DATA(vid_data), .VID_VALID(vid_valid),
      .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_CLK_SEL_OSC(tx_osc), .SELF_TEST_ACTIVE(st_active),
      .IRQ(irq));
   slbst_far_end far (.clk(clk), .lock(bc_lock), .frm_valid(bc_valid), .frm_data(bc_data),
      .frm_crc(bc_crc), .tx_data(tx_data), .tx_valid(tx_valid), .result(result));

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // video keeps changing so video leaking into the test payload shows up
   always @(posedge clk) begin
      vid_prev <= vid_data;
      vid_data <= 24'(xs());
   end

   // ---------------------------------------------------------------
   // checking and bus tasks
   // ---------------------------------------------------------------
   task automatic end_sim();
      $display("counts: %0d checks, %0d mismatches", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic avm(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 50);
      if (n >= 50) check("waitrequest", 32'(avs_waitrequest), 32'h0);
      rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] x;
      avm(1'h1, a, d, x);
   endtask

   task automatic rdchk(input logic [5:0] a, input logic [31:0] msk, input int exp, input string nm);
      logic [31:0] d;
      avm(1'h0, a, 32'h0, d);
      check(nm, d & msk, 32'(exp));
   endtask

   // sends n frames and predicts counters, mode and status
   task automatic frame(input int n, input logic t, input logic o, input logic bad);
      repeat (n) begin
         far.send(t, o, 14'(xs()), bad);
         if (bc_lock === 1'h1 && bad) begin
            fcnt = (fcnt < 255) ? fcnt + 1 : 255;
            tcnt = (in_t == 1 && tcnt < 255) ? tcnt + 1 : tcnt;
            ist = ist | 4;
         end else if (bc_lock === 1'h1 && int'(t) != in_t) begin
            in_t = int'(t);
            ist = ist | (t ? 1 : 2);
            fcnt = t ? 0 : fcnt;
            tcnt = t ? 0 : tcnt;
         end
      end
      repeat (4) @(posedge clk);
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      end_sim();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n = 1'h0;
      avs_address = 6'h00;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_writedata = 32'h0;
      vid_valid = 1'h0;
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      rdchk(slbst_pkg::ADDR_LINK, 32'h3, 0, "link");
      rdchk(6'h3C, 32'hFFFFFFFF, 0, "unmapped");
      frame(2, 1'h0, 1'h0, 1'h1);
      frame(1, 1'h1, 1'h0, 1'h0);
      rdchk(slbst_pkg::ADDR_FCNT, 32'hFF, fcnt, "fcnt unlocked");
      check("active unlocked", 32'(st_active), 32'h0);
      $display("test unlocked done");
      far.set_lock(1'h1);
      wr(slbst_pkg::ADDR_IEN, 32'h7);
      frame(2, 1'h0, 1'h0, 1'h1);
      rdchk(slbst_pkg::ADDR_FCNT, 32'hFF, fcnt, "fcnt normal");
      rdchk(slbst_pkg::ADDR_ISTAT, 32'h7, ist, "istat crc");
      check("irq set", 32'(irq), 32'h1);
      wr(slbst_pkg::ADDR_ICLR, 32'h7);
      ist = 0;
      repeat (2) @(posedge clk);
      check("irq clear", 32'(irq), 32'h0);
      $display("test crc done");
      frame(1, 1'h1, 1'h1, 1'h0);
      check("active", 32'(st_active), 32'h1);
      check("osc", 32'(tx_osc), 32'h1);
      rdchk(slbst_pkg::ADDR_FCNT, 32'hFF, fcnt, "fcnt entry");
      rdchk(slbst_pkg::ADDR_LINK, 32'h3, 3, "link test");
      wr(slbst_pkg::ADDR_CTRL, 32'h20);
      repeat (3) @(posedge clk);
      check("tx_valid test", 32'(tx_valid), 32'h1);
      check("payload", 32'(tx_data[23:0]), tx_data[24] ? 32'h0 : 32'hFFFFFF);
      check("result live", 32'(result), 32'h1);
      wr(slbst_pkg::ADDR_CTRL, 32'h0);
      frame(3, 1'h1, 1'h1, 1'h1);
      frame(1, 1'h0, 1'h0, 1'h1);
      check("active bad exit", 32'(st_active), 32'h1);
      check("result held", 32'(result), 32'h1);
      rdchk(slbst_pkg::ADDR_FCNT, 32'hFF, fcnt, "fcnt test");
      rdchk(slbst_pkg::ADDR_TCNT, 32'hFF, tcnt, "tcnt test");
      $display("test entry done");
      frame(1, 1'h0, 1'h0, 1'h0);
      check("active exit", 32'(st_active), 32'h0);
      check("osc exit", 32'(tx_osc), 32'h0);
      rdchk(slbst_pkg::ADDR_ISTAT, 32'h7, ist, "istat");
      check("irq exit", 32'(irq), 32'h1);
      wr(slbst_pkg::ADDR_IEN, 32'h0);
      repeat (2) @(posedge clk);
      check("irq masked", 32'(irq), 32'h0);
      wr(slbst_pkg::ADDR_CTRL, 32'h20);
      vid_valid <= 1'h1;
      repeat (3) @(posedge clk);
      check("tx_valid video", 32'(tx_valid), 32'h1);
      check("video", 32'(tx_data[23:0] ^ {24{tx_data[24]}} ^ slbst_pkg::SCR_SEED), 32'(vid_prev));
      wr(slbst_pkg::ADDR_CTRL, 32'h0);
      vid_valid <= 1'h0;
      repeat (3) @(posedge clk);
      check("tx_valid normal", 32'(tx_valid), 32'h0);
      frame(2, 1'h0, 1'h0, 1'h1);
      rdchk(slbst_pkg::ADDR_TCNT, 32'hFF, tcnt, "tcnt held");
      wr(slbst_pkg::ADDR_CTRL, 32'h3);
      fcnt = 0;
      tcnt = 0;
      rdchk(slbst_pkg::ADDR_FCNT, 32'hFF, fcnt, "fcnt clr");
      rdchk(slbst_pkg::ADDR_TCNT, 32'hFF, tcnt, "tcnt clr");
      frame(260, 1'h0, 1'h0, 1'h1);
      rdchk(slbst_pkg::ADDR_FCNT, 32'hFF, fcnt, "fcnt sat");
      $display("test exit done");
      frame(1, 1'h1, 1'h0, 1'h0);
      check("osc int", 32'(tx_osc), 32'h0);
      rdchk(slbst_pkg::ADDR_TCNT, 32'hFF, tcnt, "tcnt reentry");
      frame(260, 1'h1, 1'h0, 1'h1);
      rdchk(slbst_pkg::ADDR_TCNT, 32'hFF, tcnt, "tcnt sat");
      check("result reentry", 32'(result), 32'h1);
      $display("test reentry done");
      end_sim();
   end
endmodule // test_serial_link_link_self_test
